// ===== hw/rbs_pkg.sv
// Purpose: Constants and types for the reset and boot-select block.
// Assumes: One 100 MHz clock; chip reset from the board, active low.
// Notes: Operation summary follows.
package rbs_pkg;

  localparam int unsigned CLK_MHZ = 100;
  // Internal reset sequence length in ns
  localparam int unsigned RESET_SEQ_NS = 500;
  localparam int unsigned RESET_SEQ_CYC = (RESET_SEQ_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EPROM_WAITS = 16;
  localparam int unsigned NUM_IRQ = 4;
  localparam int unsigned SOFT_RST_POS = 0;

  localparam logic [31:0] START_IRQ0 = 32'h3000_0000;
  localparam logic [31:0] START_IRQ1 = 32'h3800_0000;
  localparam logic [31:0] START_IRQ2 = 32'h8000_0000;
  localparam logic [31:0] START_IRQ3 = 32'h0000_0000;
  localparam logic [3:0] VEC_ENABLE_RESET = 4'hF;
  localparam logic [7:0] EMU_CTL_RESET = 8'h00;

  typedef enum logic [1:0] {
    RBS_BOOT_EPROM = 2'h0,
    RBS_BOOT_MASTER = 2'h1,
    RBS_BOOT_LINK = 2'h2,
    RBS_BOOT_NONE = 2'h3
  } rbs_boot_t;

  typedef enum logic [2:0] {
    RBS_ST_RESET = 3'h0,
    RBS_ST_IDLE = 3'h1,
    RBS_ST_LOAD = 3'h2,
    RBS_ST_RUN = 3'h3
  } rbs_state_t;

  // Start request handed to the core
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic external;
  } rbs_start_t;

  // One EPROM read request
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } rbs_eprom_rd_t;

endpackage : rbs_pkg

// ===== hw/rbs_packer.sv
// Purpose: Packs EPROM bytes into 32-bit instruction words.
// Assumes: Bytes arrive in ascending address order, least significant first.
// Notes: Acts as the byte packing path of DMA channel 0.
module rbs_packer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  // Byte side
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Word side
  output logic word_valid_o,
  output logic [31:0] word_o
);

  logic [1:0] cnt;
  logic [23:0] acc;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 2'h0;
      acc <= 24'h000000;
      word_valid_o <= 1'b0;
      word_o <= 32'h00000000;
    end else if (clear_i) begin
      cnt <= 2'h0;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (byte_valid_i) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
          word_o <= {byte_i, acc};
          word_valid_o <= 1'b1;
        end else begin
          acc <= {byte_i, acc[23:8]};
        end
      end
    end
  end

endmodule // rbs_packer

// ===== hw/rbs_top.sv
// Purpose: Reset levels, reset-complete output and boot start selection.
// Assumes: All inputs synchronous to clk_i; boot mode strapped.
// Notes: Core reset is separate from I/O reset.
module rbs_top #(
  parameter int unsigned BOOT_WORDS = 256,
  parameter int unsigned SEQ_CYC = rbs_pkg::RESET_SEQ_CYC
) (
  // Clock and chip reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Straps and control
  input wire logic [1:0] boot_mode_i,
  input wire logic emu_ctl_we_i,
  input wire logic [7:0] emu_ctl_wdata_i,
  // Interrupts
  input wire logic [3:0] external_interrupt_lines_i,
  // Boot loads by master or link port finished
  input wire logic load_done_i,
  // EPROM data
  input wire logic eprom_valid_i,
  input wire logic [7:0] eprom_data_i,
  // Reset and core control
  output logic reset_complete_n_o,
  output logic core_reset_n_o,
  output logic core_idle_o,
  output rbs_pkg::rbs_start_t start_o,
  output logic [3:0] vec_enable_o,
  // EPROM access
  output logic boot_memory_select_n_o,
  output rbs_pkg::rbs_eprom_rd_t eprom_rd_o,
  output logic [4:0] eprom_wait_o,
  // Packed boot words
  output logic boot_word_valid_o,
  output logic [31:0] boot_word_o
);

  // Refuse sizes that the 24-bit byte address or 16-bit counter cannot hold
  if (BOOT_WORDS == 0 || BOOT_WORDS > (1 << 22)) begin : g_bad_words
    $error("BOOT_WORDS out of range");
  end
  if (SEQ_CYC == 0 || SEQ_CYC > 65535) begin : g_bad_seq
    $error("SEQ_CYC out of range");
  end

  rbs_pkg::rbs_state_t state;
  rbs_pkg::rbs_boot_t mode;
  logic [15:0] seq_cnt;
  logic [7:0] emulation_control_reg;
  logic core_soft_reset_bit;
  logic [4:0] wait_cnt;
  logic [23:0] rd_addr;
  logic [31:0] words_done;
  logic rd_pending;
  logic [31:0] next_addr;
  logic next_ext;
  logic pack_valid;

  assign core_soft_reset_bit = emulation_control_reg[rbs_pkg::SOFT_RST_POS];

  // Emulation control: soft reset bit self-clears after one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      emulation_control_reg <= rbs_pkg::EMU_CTL_RESET;
    end else if (emu_ctl_we_i) begin
      emulation_control_reg <= emu_ctl_wdata_i;
    end else if (core_soft_reset_bit) begin
      emulation_control_reg[rbs_pkg::SOFT_RST_POS] <= 1'b0;
    end
  end

  // Internal reset sequence counter, chip reset only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_cnt <= 16'h0000;
      reset_complete_n_o <= 1'b0;
    end else if (seq_cnt != SEQ_CYC[15:0]) begin
      seq_cnt <= seq_cnt + 16'h0001;
    end else begin
      reset_complete_n_o <= 1'b1;
    end
  end

  // Boot mode latched at the end of the reset sequence
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode <= rbs_pkg::RBS_BOOT_NONE;
    end else if (state == rbs_pkg::RBS_ST_RESET) begin
      mode <= rbs_pkg::rbs_boot_t'(boot_mode_i);
    end
  end

  // Lowest-numbered asserted line wins
  always_comb begin
    next_addr = rbs_pkg::START_IRQ3;
    next_ext = 1'b0;
    if (external_interrupt_lines_i[0]) begin
      next_addr = rbs_pkg::START_IRQ0;
      next_ext = 1'b1;
    end else if (external_interrupt_lines_i[1]) begin
      next_addr = rbs_pkg::START_IRQ1;
      next_ext = 1'b1;
    end else if (external_interrupt_lines_i[2]) begin
      next_addr = rbs_pkg::START_IRQ2;
      next_ext = 1'b1;
    end
  end

  // Core sequencing; soft reset restarts this, the core outputs and, through RESET, the EPROM reader and packer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= rbs_pkg::RBS_ST_RESET;
      start_o <= '0;
      vec_enable_o <= 4'h0;
    end else if (core_soft_reset_bit) begin
      state <= rbs_pkg::RBS_ST_RESET;
      start_o <= '0;
      vec_enable_o <= 4'h0;
    end else begin
      start_o.valid <= 1'b0;
      case (state)
        rbs_pkg::RBS_ST_RESET: begin
          if (!reset_complete_n_o) begin
            state <= rbs_pkg::RBS_ST_RESET;
          end else begin
            vec_enable_o <= rbs_pkg::VEC_ENABLE_RESET;
            if (mode == rbs_pkg::RBS_BOOT_NONE) begin
              state <= rbs_pkg::RBS_ST_IDLE;
            end else begin
              state <= rbs_pkg::RBS_ST_LOAD;
            end
          end
        end
        rbs_pkg::RBS_ST_LOAD: begin
          if ((mode == rbs_pkg::RBS_BOOT_EPROM &&
               words_done == BOOT_WORDS) ||
              (mode != rbs_pkg::RBS_BOOT_EPROM && load_done_i)) begin
            state <= rbs_pkg::RBS_ST_IDLE;
          end
        end
        rbs_pkg::RBS_ST_IDLE: begin
          if (|external_interrupt_lines_i) begin
            start_o.valid <= 1'b1;
            start_o.addr <= next_addr;
            start_o.external <= next_ext;
            state <= rbs_pkg::RBS_ST_RUN;
          end
        end
        rbs_pkg::RBS_ST_RUN: begin
          state <= rbs_pkg::RBS_ST_RUN;
        end
        default: begin
          state <= rbs_pkg::RBS_ST_RESET;
        end
      endcase
    end
  end

  assign core_reset_n_o = (state != rbs_pkg::RBS_ST_RESET);
  assign core_idle_o = (state != rbs_pkg::RBS_ST_RUN);

  // EPROM reader: sixteen wait cycles per byte read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt <= 5'h00;
      rd_addr <= 24'h000000;
      rd_pending <= 1'b0;
      words_done <= 32'h00000000;
      boot_memory_select_n_o <= 1'b1;
      eprom_rd_o <= '0;
    end else if (state == rbs_pkg::RBS_ST_LOAD &&
                 mode == rbs_pkg::RBS_BOOT_EPROM &&
                 words_done != BOOT_WORDS) begin
      boot_memory_select_n_o <= 1'b0;
      eprom_rd_o.req <= 1'b0;
      if (!rd_pending) begin
        rd_pending <= 1'b1;
        wait_cnt <= 5'h00;
        eprom_rd_o.req <= 1'b1;
        eprom_rd_o.addr <= rd_addr;
      end else if (wait_cnt != 5'(rbs_pkg::EPROM_WAITS)) begin
        wait_cnt <= wait_cnt + 5'h01;
      end else if (eprom_valid_i) begin
        rd_pending <= 1'b0;
        rd_addr <= rd_addr + 24'h000001;
        if (rd_addr[1:0] == 2'h3) begin
          words_done <= words_done + 32'h00000001;
        end
      end
    end else begin
      boot_memory_select_n_o <= 1'b1;
      eprom_rd_o.req <= 1'b0;
      rd_pending <= 1'b0;
      if (state == rbs_pkg::RBS_ST_RESET) begin
        rd_addr <= 24'h000000;
        words_done <= 32'h00000000;
      end
    end
  end

  assign eprom_wait_o = wait_cnt;
  assign pack_valid = rd_pending && eprom_valid_i &&
                      wait_cnt == 5'(rbs_pkg::EPROM_WAITS) &&
                      !boot_memory_select_n_o;

  rbs_packer u_packer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clear_i(state == rbs_pkg::RBS_ST_RESET),
    .byte_valid_i(pack_valid),
    .byte_i(eprom_data_i),
    .word_valid_o(boot_word_valid_o),
    .word_o(boot_word_o)
  );

endmodule // rbs_top

// ===== test/rbs_chk.sv
// Purpose: Port checks for reset and boot start.
// Assumes: One clock domain.
// Notes: Start address is recomputed from the sampled lines.
module rbs_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Inputs
  input wire logic emu_ctl_we_i,
  input wire logic [7:0] emu_ctl_wdata_i,
  input wire logic [3:0] external_interrupt_lines_i,
  // Outputs
  input wire logic reset_complete_n_o,
  input wire logic core_reset_n_o,
  input wire logic core_idle_o,
  input wire rbs_pkg::rbs_start_t start_o,
  input wire logic [3:0] vec_enable_o,
  input wire logic boot_memory_select_n_o,
  input wire rbs_pkg::rbs_eprom_rd_t eprom_rd_o,
  input wire logic [4:0] eprom_wait_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [32:0] exp_st;
  always_comb begin
    casez (external_interrupt_lines_i)
      4'b???1: exp_st = {32'h3000_0000, 1'h1};
      4'b??10: exp_st = {32'h3800_0000, 1'h1};
      4'b?100: exp_st = {32'h8000_0000, 1'h1};
      default: exp_st = 33'h0_0000_0000;
    endcase
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_reset_idle: assert property (
    !core_reset_n_o |-> core_idle_o) else $error("core busy in reset");
  a_vec_clear: assert property (
    !core_reset_n_o |-> vec_enable_o == 4'h0) else $error("vec in reset");
  a_vec_start: assert property (
    start_o.valid |-> vec_enable_o == 4'hF) else $error("vec not set");
  a_core_after_seq: assert property (
    core_reset_n_o |-> reset_complete_n_o) else $error("core ran early");
  a_soft_core_only: assert property (
    emu_ctl_we_i && emu_ctl_wdata_i[0] && core_reset_n_o |=>
    ##1 (!core_reset_n_o && reset_complete_n_o)) else $error("soft reset");
  a_start_addr: assert property (
    start_o.valid |-> start_o[32:0] == $past(exp_st)) else $error("addr");
  a_start_idle: assert property (
    start_o.valid |-> $past(core_idle_o)) else $error("start not idle");
  a_one_start: assert property (
    start_o.valid |=> !start_o.valid [*3]) else $error("second start");
  a_eprom_waits: assert property (
    eprom_rd_o.req |=> eprom_wait_o == 5'h01 ##15 eprom_wait_o == 5'h10)
    else $error("eprom waits");
  c_start_int: cover property (start_o.valid && !start_o.external);
  c_soft: cover property (emu_ctl_we_i && core_reset_n_o);
  c_eprom: cover property (!boot_memory_select_n_o && eprom_rd_o.req);
endmodule // rbs_chk
bind rbs_top rbs_chk i_chk (.clk_i, .nrst_i, .emu_ctl_we_i, .emu_ctl_wdata_i,
  .external_interrupt_lines_i, .reset_complete_n_o, .core_reset_n_o,
  .core_idle_o, .start_o, .vec_enable_o, .boot_memory_select_n_o,
  .eprom_rd_o, .eprom_wait_o);

// ===== test/rbs_eprom_model.sv
// Purpose: Byte-wide boot EPROM on the far side.
// Assumes: Byte at address a holds 8'h40 + a, so a wrong address shows.
// Notes: Data shows the inverse of the last byte when not valid.
module rbs_eprom_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Device side
  input wire logic bms_n_i,
  input wire rbs_pkg::rbs_eprom_rd_t rd_i,
  input wire logic [4:0] wait_i,
  // Answer
  output logic valid_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cur;
  assign valid_o = !bms_n_i && wait_i == 5'h10;
  assign data_o = valid_o ? cur : ~cur;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur <= 8'h00;
    end else if (rd_i.req) begin
      cur <= 8'h40 + rd_i.addr[7:0];
    end
  end
endmodule // rbs_eprom_model

// ===== test/rbs_top_tb_top.sv
// Purpose: Self-checking bench for reset and boot start.
// Assumes: Short reset sequence and two boot words.
// Notes: No-boot starts come from a table; other cases follow.
module rbs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEQ = 2;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] mode = 2'h3;
  logic we = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [3:0] irq = 4'h0;
  logic ld = 1'b0;
  logic ev, core_n, rc_n, idle, bms_n, wv;
  logic [7:0] ed;
  logic [4:0] wt;
  logic [3:0] vec;
  logic [31:0] word;
  rbs_pkg::rbs_start_t st;
  rbs_pkg::rbs_eprom_rd_t rd;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // Board ties reset-complete to the memory power-on reset input
  logic por_n;
  assign por_n = rc_n;
  // Lines asserted, then expected address and external flag
  logic [36:0] rows [5] = '{{4'h1, 32'h3000_0000, 1'h1},
    {4'h2, 32'h3800_0000, 1'h1}, {4'h4, 32'h8000_0000, 1'h1},
    {4'h8, 32'h0000_0000, 1'h0}, {4'h6, 32'h3800_0000, 1'h1}};
  rbs_top #(.BOOT_WORDS(2), .SEQ_CYC(SEQ)) i_dut (.clk_i, .nrst_i,
    .boot_mode_i(mode), .emu_ctl_we_i(we), .emu_ctl_wdata_i(wd),
    .external_interrupt_lines_i(irq), .load_done_i(ld),
    .eprom_valid_i(ev), .eprom_data_i(ed), .reset_complete_n_o(rc_n),
    .core_reset_n_o(core_n), .core_idle_o(idle), .start_o(st),
    .vec_enable_o(vec), .boot_memory_select_n_o(bms_n), .eprom_rd_o(rd),
    .eprom_wait_o(wt), .boot_word_valid_o(wv), .boot_word_o(word));
  rbs_eprom_model i_eprom (.clk_i, .nrst_i, .bms_n_i(bms_n), .rd_i(rd),
    .wait_i(wt), .valid_o(ev), .data_o(ed));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  task automatic check(input logic [33:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chip_reset(input logic [1:0] m);
    int n = 0;
    tick(1);
    nrst_i = 1'b0;
    mode = m;
    irq = 4'h0;
    tick(6);
    check({rc_n, core_n, idle}, 34'h1, "in reset");
    nrst_i = 1'b1;
    do begin
      tick(1);
      n++;
    end while (rc_n !== 1'b1 && n < 100);
    check(n, SEQ + 1, "sequence edges");
    check(por_n, 1'b1, "memory power-on reset");
  endtask
  task automatic wait_start(input logic [32:0] exp);
    int n = 0;
    while (st.valid !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    check(st, {1'b1, exp}, "start");
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      chip_reset(2'h3);
      tick(3);
      check({idle, st.valid, vec}, 34'h2F, "waiting");
      irq = rows[i][36:33];
      wait_start(rows[i][32:0]);
      irq = 4'hF;
      tick(4);
      check(st, {1'b0, rows[i][32:0]}, "later line");
    end
    irq = 4'h2;
    we = 1'b1;
    wd = 8'h01;
    tick(1);
    we = 1'b0;
    tick(1);
    check({core_n, rc_n}, 34'h1, "soft reset");
    wait_start({32'h3800_0000, 1'h1});
    check(rc_n, 1'b1, "chip sequence kept");
    for (int m = 1; m < 3; m++) begin
      chip_reset(m[1:0]);
      irq = 4'h8;
      tick(5);
      check({idle, st.valid}, 34'h2, "loading");
      ld = 1'b1;
      tick(1);
      ld = 1'b0;
      wait_start(33'h0);
    end
    chip_reset(2'h0);
    tick(3);
    check(bms_n, 1'b0, "eprom select");
    for (int w = 0; w < 2; w++) begin
      int n;
      n = 0;
      while (wv !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      check(word, 32'h4342_4140 + w * 32'h0404_0404, "word");
      tick(1);
    end
    irq = 4'h4;
    wait_start({32'h8000_0000, 1'h1});
    check(bms_n, 1'b1, "select released");
    end_sim();
  end
endmodule // rbs_top_tb_top
